// [fidp_flash_id_parallel_mode.v]
// command interpreter for identification reads, parallel mode and write timing
`timescale 1ns/1ps
`include "fidp_regs.vh"
module fidp_flash_id_parallel_mode #(
    parameter [7:0] MAKER_ID = 8'h5A,     // arbitrary value
    parameter [7:0] DEVICE_ID = 8'h17,    // arbitrary value
    parameter [7:0] MEM_TYPE = 8'h20,     // arbitrary value
    parameter [7:0] MEM_DENSITY = 8'h18,  // arbitrary value
    parameter [7:0] SIGNATURE = 8'h17,    // arbitrary value
    parameter integer ADDR_BITS = 8,
    parameter [31:0] CYC_WRSR = `FIDP_CYC_WRSR,
    parameter [31:0] CYC_SE = `FIDP_CYC_SE,
    parameter [31:0] CYC_BE = `FIDP_CYC_BE,
    parameter [31:0] CYC_PP = `FIDP_CYC_PP
) (
    input wire mclk,
    input wire rst_n,
    input wire clkEn,
    input wire csN,
    input wire byteValid,
    input wire [7:0] byteIn,
    output reg [7:0] byteOut,
    output reg byteOutValid,
    output reg parallelMode,
    output wire busy,
    output reg [7:0] statusReg
);

    // sequencer states
    // opcode state: waiting for the first byte after select
    // address state: collecting three address bytes, high byte first
    // data state: one write byte launches the timed internal operation
    // output state: each host byte slot returns one answer byte
    // ignore state: the rest of the select is dropped
    // a high chip select always returns to the opcode state, so a cut
    // command leaves nothing half done except a launched write, which
    // is committed once its data byte, or for an erase its third address byte, is in
    localparam [2:0] ST_OP = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_DATA = 3'd2;
    localparam [2:0] ST_OUT = 3'd3;
    localparam [2:0] ST_IGNORE = 3'd4;

    // command kinds, decided on the opcode byte
    // identifier read answers alternate maker and device codes
    // three-byte identification answers maker, type, density
    // signature read answers the signature byte on every slot
    // status read returns the live status byte
    // array read walks upward through the model array
    // status write and program or erase use the shared write timer
    localparam [2:0] K_NONE = 3'd0;
    localparam [2:0] K_IDS = 3'd1;
    localparam [2:0] K_JEDEC = 3'd2;
    localparam [2:0] K_SIG = 3'd3;
    localparam [2:0] K_RDSR = 3'd4;
    localparam [2:0] K_READ = 3'd5;
    localparam [2:0] K_WRSR = 3'd6;
    localparam [2:0] K_PP = 3'd7;

    // small array model: erased cells read FFh
    reg [7:0] mem [0:(1<<ADDR_BITS)-1];

    // register roles
    // state_q and kind_q: where the current select stands
    // op_q: opcode of this select, separates erase from program
    // addrCnt_q: address bytes seen so far
    // addr_q: address, shifted in high byte first
    // idx_q: answer position inside the select
    // timer_q: cycles left of the internal write operation
    // wel_q: set by write enable, cleared only by write disable, not at the end of a write op
    // pend_q: what to commit when the timer runs out
    // pendData_q and pendAddr_q: the byte and cell of a program
    reg [2:0] state_q;
    reg [2:0] kind_q;
    reg [7:0] op_q;
    reg [1:0] addrCnt_q;
    reg [23:0] addr_q;
    reg [1:0] idx_q;
    reg [31:0] timer_q;
    reg wel_q;
    reg [1:0] pend_q;
    reg [7:0] pendData_q;
    reg [ADDR_BITS-1:0] pendAddr_q;
    integer i;
    integer j;

    function isIdOp;
        input [7:0] op;
        begin
            isIdOp = (op == `FIDP_OP_IDS0) || (op == `FIDP_OP_IDS1) ||
                     (op == `FIDP_OP_IDS2) || (op == `FIDP_OP_IDS3);
        end
    endfunction

    // internal operation pending: 0 none, 1 status write, 2 program, 3 erase
    assign busy = statusReg[`FIDP_SR_WIP];

    // identification byte by position; order flips on the low address bit
    function [7:0] idByte;
        input [2:0] kind;
        input lowBit;
        input [1:0] idx;
        begin
            if (kind == K_JEDEC) begin
                case (idx)
                    2'd0: idByte = MAKER_ID;
                    2'd1: idByte = MEM_TYPE;
                    default: idByte = MEM_DENSITY;
                endcase
            end else if (lowBit ^ idx[0]) begin
                idByte = DEVICE_ID;
            end else begin
                idByte = MAKER_ID;
            end
        end
    endfunction

    // main sequencer; holds everything still while clkEn is low
    // command summary
    // identifier read: opcode, three address bytes, then dummies;
    // only address bit zero picks which code leads
    // identification: opcode, then dummies; density is sent again as the
    // fourth answer, then the answers wrap back to the maker code
    // signature read: opcode, three dummy address bytes, dummies
    // status read: opcode, then dummies, live value each time
    // array read: opcode, three address bytes, then dummies; while a
    // write runs the array is hidden behind the status byte
    // parallel on and off: opcode alone, effect at the next edge
    // write enable and disable: opcode alone, refused while busy
    // status write: opcode plus one data byte, needs the latch set
    // program: opcode, address, one data byte; bits only go to zero
    // erase: opcode and address; the whole model array is cleared
    // when the timer runs out, since the model is smaller than a
    // sector and a partial clear would leave stale cells behind
    // every write op clears the latch and the busy bit at its end
    // trade-off: durations use typical figures, well inside maxima,
    // to keep simulation short once the cycle counts are scaled down
    // limitation: later data bytes of a program are dropped, only
    // one byte per command is modelled
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_OP;
            kind_q <= K_NONE;
            op_q <= 8'h00;
            addrCnt_q <= 2'd0;
            addr_q <= 24'h000000;
            idx_q <= 2'd0;
            timer_q <= 32'h00000000;
            wel_q <= 1'b0;
            pend_q <= 2'd0;
            pendData_q <= 8'h00;
            pendAddr_q <= {ADDR_BITS{1'b0}};
            byteOut <= 8'h00;
            byteOutValid <= 1'b0;
            parallelMode <= 1'b0; // reset stands in for the power cycle
            statusReg <= `FIDP_STATUS_RESET;
        end else if (clkEn) begin
            byteOutValid <= 1'b0;
            // internal operation timer; busy drops when it expires
            if (busy) begin
                if (timer_q > 32'h00000001) begin
                    timer_q <= timer_q - 32'h00000001;
                end else begin
                    statusReg[`FIDP_SR_WIP] <= 1'b0;
                    statusReg[`FIDP_SR_WEL] <= 1'b0;
                    if (pend_q == 2'd1) begin
                        statusReg[7:2] <= pendData_q[7:2];
                    end else if (pend_q == 2'd2) begin
                        mem[pendAddr_q] <= mem[pendAddr_q] & pendData_q;
                    end else if (pend_q == 2'd3) begin
                        // erase lands in one edge so no cell is read half erased
                        for (j = 0; j < (1<<ADDR_BITS); j = j + 1) begin
                            mem[j] <= `FIDP_ERASED_BYTE;
                        end
                    end
                    pend_q <= 2'd0;
                end
            end
            if (csN) begin
                state_q <= ST_OP;
                addrCnt_q <= 2'd0;
                idx_q <= 2'd0;
            end else if (byteValid) begin
                case (state_q)
                    ST_OP: begin
                        op_q <= byteIn;
                        addrCnt_q <= 2'd0;
                        idx_q <= 2'd0;
                        state_q <= ST_IGNORE;
                        if (isIdOp(byteIn)) begin
                            kind_q <= K_IDS;
                            state_q <= ST_ADDR;
                        end else if (byteIn == `FIDP_OP_JEDEC) begin
                            kind_q <= K_JEDEC;
                            state_q <= ST_OUT;
                        end else if (byteIn == `FIDP_OP_WAKE) begin
                            kind_q <= K_SIG; // wake plus signature
                            state_q <= ST_ADDR;
                        end else if (byteIn == `FIDP_OP_RDSR) begin
                            kind_q <= K_RDSR;
                            state_q <= ST_OUT;
                        end else if (byteIn == `FIDP_OP_READ) begin
                            kind_q <= K_READ;
                            state_q <= ST_ADDR;
                        end else if (byteIn == `FIDP_OP_PAR_ON) begin
                            parallelMode <= 1'b1;
                        end else if (byteIn == `FIDP_OP_PAR_OFF) begin
                            parallelMode <= 1'b0;
                        end else if (byteIn == `FIDP_OP_WREN && !busy) begin
                            wel_q <= 1'b1;
                            statusReg[`FIDP_SR_WEL] <= 1'b1;
                        end else if (byteIn == `FIDP_OP_WRDI && !busy) begin
                            wel_q <= 1'b0;
                            statusReg[`FIDP_SR_WEL] <= 1'b0;
                        end else if (byteIn == `FIDP_OP_WRSR && statusReg[`FIDP_SR_WEL]
                                     && !busy) begin
                            kind_q <= K_WRSR;
                            state_q <= ST_DATA;
                        end else if ((byteIn == `FIDP_OP_SE || byteIn == `FIDP_OP_BE ||
                                      byteIn == `FIDP_OP_PP) && statusReg[`FIDP_SR_WEL]
                                     && !busy) begin
                            kind_q <= K_PP;
                            state_q <= ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        addr_q <= {addr_q[15:0], byteIn};
                        addrCnt_q <= addrCnt_q + 2'd1;
                        if (addrCnt_q == 2'd2) begin
                            if (kind_q == K_PP && op_q != `FIDP_OP_PP) begin
                                // erase starts at the end of the address
                                statusReg[`FIDP_SR_WIP] <= 1'b1;
                                pend_q <= 2'd3;
                                timer_q <= (op_q == `FIDP_OP_SE) ? CYC_SE : CYC_BE;
                                state_q <= ST_IGNORE;
                            end else if (kind_q == K_PP) begin
                                state_q <= ST_DATA;
                            end else begin
                                state_q <= ST_OUT;
                            end
                        end
                    end
                    ST_DATA: begin
                        // one data byte starts the timed write; later bytes ignored
                        statusReg[`FIDP_SR_WIP] <= 1'b1;
                        pendData_q <= byteIn;
                        pendAddr_q <= addr_q[ADDR_BITS-1:0];
                        pend_q <= (kind_q == K_WRSR) ? 2'd1 : 2'd2;
                        timer_q <= (kind_q == K_WRSR) ? CYC_WRSR : CYC_PP;
                        state_q <= ST_IGNORE;
                    end
                    ST_OUT: begin
                        // each host byte slot clocks out one answer byte
                        byteOutValid <= 1'b1;
                        idx_q <= idx_q + 2'd1;
                        addr_q <= addr_q + 24'h000001;
                        case (kind_q)
                            K_IDS: byteOut <= idByte(K_IDS, addr_q[0], idx_q);
                            K_JEDEC: byteOut <= idByte(K_JEDEC, 1'b0,
                                                       (idx_q == 2'd3) ? 2'd2 : idx_q);
                            K_SIG: byteOut <= SIGNATURE;
                            K_RDSR: byteOut <= statusReg;
                            K_READ: byteOut <= busy ? statusReg : mem[addr_q[ADDR_BITS-1:0]];
                            default: byteOut <= 8'h00;
                        endcase
                        if (kind_q == K_IDS) begin
                            addr_q <= addr_q; // only the low address bit matters
                        end
                    end
                    default: begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // delivered state: every cell erased
    initial begin
        for (i = 0; i < (1<<ADDR_BITS); i = i + 1) begin
            mem[i] = `FIDP_ERASED_BYTE;
        end
    end

endmodule

// [fidp_host_model.sv]
// host controller model: selects the device and hands it whole bytes
`timescale 1ns/1ps
module fidp_host_model (
    input wire mclk,
    output reg csN,
    output reg byteValid,
    output reg [7:0] byteIn,
    input wire byteOutValid,
    input wire [7:0] byteOut
);
    initial begin
        csN = 1'b1;
        byteValid = 1'b0;
        byteIn = 8'h00;
    end
    // deselected wait after power-up before the first select
    task power_wait(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    task sel;
        @(posedge mclk) csN <= 1'b0;
    endtask
    task desel;
        begin
            @(posedge mclk) csN <= 1'b1;
            @(posedge mclk);
        end
    endtask
    // one byte per call, then a gap; slow pacing keeps within the parallel clock limit
    task xfer(input [7:0] b, output [7:0] r, output got);
        begin
            got = 1'b0;
            r = 8'h00;
            @(posedge mclk);
            byteValid <= 1'b1;
            byteIn <= b;
            @(posedge mclk);
            byteValid <= 1'b0;
            byteIn <= ~b; // released line shows inverse so stale data never passes
            repeat (3) begin
                @(posedge mclk);
                if (byteOutValid === 1'b1 && !got) begin
                    r = byteOut;
                    got = 1'b1;
                end
            end
        end
    endtask
endmodule

// [fidp_id_properties.sv]
// concurrent checks on the identification and parallel-mode command block
`timescale 1ns/1ps
module fidp_id_checker #(
    parameter [7:0] MAKER_ID = 8'h01,
    parameter [7:0] DEVICE_ID = 8'h02,
    parameter [7:0] MEM_TYPE = 8'h03,
    parameter [7:0] MEM_DENSITY = 8'h04,
    parameter [31:0] CYC_WRSR = 32'h14,
    parameter [31:0] CYC_SE = 32'h14,
    parameter [31:0] CYC_BE = 32'h14,
    parameter [31:0] CYC_PP = 32'h14
) (
    input wire mclk,
    input wire rst_n,
    input wire clkEn,
    input wire csN,
    input wire byteValid,
    input wire [7:0] byteIn,
    input wire [7:0] byteOut,
    input wire byteOutValid,
    input wire parallelMode,
    input wire busy,
    input wire [7:0] statusReg
);
    reg [2:0] byteCnt_q = 3'h0;
    reg [1:0] ansCnt_q = 2'h0;
    reg [7:0] opCode_q = 8'h00;
    reg [7:0] wrOp_q = 8'h00;
    reg lowBit_q = 1'b0;
    reg offSeen_q = 1'b0;
    reg [31:0] busyCnt_q = 32'h0;
    wire take = clkEn && !csN && byteValid;
    wire idOp = opCode_q == 8'h90 || opCode_q == 8'hEF || opCode_q == 8'hDF || opCode_q == 8'hCF;
    wire [31:0] limit = wrOp_q == 8'h01 ? CYC_WRSR : wrOp_q == 8'h20 ? CYC_SE :
        wrOp_q == 8'hD8 ? CYC_BE : CYC_PP;
    // track position inside a select; answers are indexed so each one has a known value
    always @(posedge mclk) begin
        if (!rst_n || csN) begin
            byteCnt_q <= 3'h0;
            ansCnt_q <= 2'h0;
        end else begin
            if (take && byteCnt_q != 3'h7) byteCnt_q <= byteCnt_q + 3'h1;
            if (byteOutValid && ansCnt_q != 2'h3) ansCnt_q <= ansCnt_q + 2'h1;
        end
        if (take && byteCnt_q == 3'h0) opCode_q <= byteIn;
        if (take && byteCnt_q == 3'h0 && !busy) wrOp_q <= byteIn;
        if (take && byteCnt_q == 3'h3) lowBit_q <= byteIn[0];
        offSeen_q <= take && byteCnt_q == 3'h0 && byteIn == 8'h45;
        busyCnt_q <= busy ? busyCnt_q + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_reset_clears: assert property (disable iff (1'b0) !rst_n && clkEn |=>
        statusReg == 8'h00 && !parallelMode) else $error("reset left state set");
    a_id_first: assert property (byteOutValid && idOp && ansCnt_q == 2'h0 |->
        byteOut == (lowBit_q ? DEVICE_ID : MAKER_ID)) else $error("wrong first id byte");
    a_id_alternate: assert property (byteOutValid && idOp && ansCnt_q == 2'h1 |->
        byteOut == (lowBit_q ? MAKER_ID : DEVICE_ID)) else $error("wrong second id byte");
    a_ident_triple: assert property (byteOutValid && opCode_q == 8'h9F && ansCnt_q < 2'h3 |->
        byteOut == (ansCnt_q == 2'h0 ? MAKER_ID : ansCnt_q == 2'h1 ? MEM_TYPE : MEM_DENSITY))
        else $error("wrong ident byte");
    a_id_answers: assert property (take && idOp && byteCnt_q >= 3'h4 |=> byteOutValid)
        else $error("dummy byte not answered");
    a_par_enter: assert property (take && byteCnt_q == 3'h0 && byteIn == 8'h55 |->
        ##[1:2] parallelMode) else $error("parallel mode not entered");
    a_par_hold: assert property ($fell(parallelMode) && $past(rst_n) |->
        offSeen_q || $past(offSeen_q)) else $error("parallel mode left without exit");
    a_busy_limit: assert property (busy |-> busyCnt_q <= limit + 32'h2)
        else $error("write cycle too long");
endmodule
bind fidp_flash_id_parallel_mode fidp_id_checker #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID),
    .MEM_TYPE(MEM_TYPE), .MEM_DENSITY(MEM_DENSITY), .CYC_WRSR(CYC_WRSR), .CYC_SE(CYC_SE),
    .CYC_BE(CYC_BE), .CYC_PP(CYC_PP)) u_chk (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .csN(csN), .byteValid(byteValid), .byteIn(byteIn), .byteOut(byteOut),
    .byteOutValid(byteOutValid), .parallelMode(parallelMode), .busy(busy), .statusReg(statusReg));

// [fidp_regs.vh]
// constants for the flash identification and parallel-mode command block
// How it works
// - id_order_select_bit zero gives maker code first
// - address bits one to twenty-three ignored
// - opcodes 90h EFh DFh CFh read identifiers
// - parallel mode held until 45h or power cycle
// - delivered array reads back FFh everywhere
// - delivered status register reads 00h
// - status write typical 40 ms, max 100 ms
// - sector erase typical 60 ms, max 300 ms
// - block erase typical 0.7 s, max 2 s
// - byte program typical 9 us, max 300 us
// - parallel identification sends maker, type, density
`ifndef FIDP_REGS_VH
`define FIDP_REGS_VH
`define FIDP_OP_IDS0 8'h90
`define FIDP_OP_IDS1 8'hEF
`define FIDP_OP_IDS2 8'hDF
`define FIDP_OP_IDS3 8'hCF
`define FIDP_OP_JEDEC 8'h9F
`define FIDP_OP_PAR_ON 8'h55
`define FIDP_OP_PAR_OFF 8'h45
`define FIDP_OP_WAKE 8'hAB
`define FIDP_OP_RDSR 8'h05
`define FIDP_OP_WREN 8'h06
`define FIDP_OP_WRDI 8'h04
`define FIDP_OP_WRSR 8'h01
`define FIDP_OP_SE 8'h20
`define FIDP_OP_BE 8'hD8
`define FIDP_OP_PP 8'h02
`define FIDP_OP_READ 8'h03
`define FIDP_ERASED_BYTE 8'hFF
`define FIDP_STATUS_RESET 8'h00
`define FIDP_SR_WIP 0
`define FIDP_SR_WEL 1
`define FIDP_CLK_HZ 10000000
`define FIDP_T_WRSR_MS 40
`define FIDP_T_SE_MS 60
`define FIDP_T_BE_MS 700
`define FIDP_T_PP_US 9
`define FIDP_CYC_WRSR (`FIDP_T_WRSR_MS * (`FIDP_CLK_HZ / 1000))
`define FIDP_CYC_SE (`FIDP_T_SE_MS * (`FIDP_CLK_HZ / 1000))
`define FIDP_CYC_BE (`FIDP_T_BE_MS * (`FIDP_CLK_HZ / 1000))
`define FIDP_CYC_PP (`FIDP_T_PP_US * (`FIDP_CLK_HZ / 1000000))
`endif

// [testbench.sv]
// self-checking bench for the identification and parallel-mode command block
`timescale 1ns/1ps
module testbench;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg clkEn = 1'b1;
    wire csN, byteValid, byteOutValid, parallelMode, busy;
    wire [7:0] byteIn, byteOut, statusReg;
    integer miscompares = 0;
    integer cmp_count = 0;
    integer i;
    reg [7:0] ops [0:3];
    // identity values are the design defaults; they are arbitrary
    localparam [7:0] MK = 8'h5A;
    localparam [7:0] DV = 8'h17;
    localparam [7:0] MT = 8'h20;
    localparam [7:0] MD = 8'h18;
    localparam [7:0] SG = 8'h17;
    always #50 mclk = ~mclk;
    fidp_flash_id_parallel_mode #(.CYC_WRSR(32'h14), .CYC_SE(32'h1E),
        .CYC_BE(32'h28), .CYC_PP(32'h0A)) u_fidp_flash_id_parallel_mode (.mclk(mclk),
        .rst_n(rst_n), .clkEn(clkEn), .csN(csN), .byteValid(byteValid), .byteIn(byteIn),
        .byteOut(byteOut), .byteOutValid(byteOutValid), .parallelMode(parallelMode),
        .busy(busy), .statusReg(statusReg));
    fidp_host_model u_host (.mclk(mclk), .csN(csN), .byteValid(byteValid), .byteIn(byteIn),
        .byteOutValid(byteOutValid), .byteOut(byteOut));
    task end_sim;
        begin
            $display("compares %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
                miscompares = miscompares + 1;
            end
        end
    endtask
    task chkBit(input got, input exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task send(input [7:0] b);
        reg [7:0] r;
        reg g;
        u_host.xfer(b, r, g);
    endtask
    task ask(input [7:0] exp);
        reg [7:0] r;
        reg g;
        begin
            u_host.xfer(8'h00, r, g);
            chkBit(g, 1'b1);
            chk8(r, exp);
        end
    endtask
    // upper address bytes are nonzero so only the low bit may matter
    task cmd(input [7:0] op, input [7:0] lo);
        begin
            u_host.sel;
            send(op);
            send(8'hFF);
            send(8'hFE);
            send(lo);
        end
    endtask
    task rd(input [7:0] exp);
        begin
            cmd(8'h03, 8'h05);
            ask(exp);
            u_host.desel;
        end
    endtask
    // enable writes, launch one write op, then time the busy period
    task wr(input [7:0] op, input [7:0] d, input [31:0] cyc);
        integer n;
        begin
            u_host.sel;
            send(8'h06);
            u_host.desel;
            if (op == 8'h01) begin
                u_host.sel;
                send(op);
            end else cmd(op, 8'h05);
            if (op == 8'h01 || op == 8'h02) send(d);
            u_host.desel;
            chkBit(busy, 1'b1);
            n = 0;
            while (busy === 1'b1 && n < 5000) begin
                @(posedge mclk);
                n = n + 1;
            end
            chkBit(n + 5 >= cyc && n <= cyc + 1, 1'b1);
            if (n >= 5000) end_sim;
        end
    endtask
    initial begin
        ops[0] = 8'h90;
        ops[1] = 8'hEF;
        ops[2] = 8'hDF;
        ops[3] = 8'hCF;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        u_host.power_wait(3000);
        u_host.sel;
        send(8'h05);
        ask(8'h00);
        u_host.desel;
        rd(8'hFF);
        $display("delivered state done");
        for (i = 0; i < 8; i = i + 1) begin
            cmd(ops[i / 2], {7'h2A, i[0]});
            ask(i[0] ? DV : MK);
            ask(i[0] ? MK : DV);
            u_host.desel;
        end
        $display("identifier reads done");
        u_host.sel;
        send(8'h55);
        u_host.desel;
        chkBit(parallelMode, 1'b1);
        u_host.sel;
        send(8'h9F);
        ask(MK);
        ask(MT);
        ask(MD);
        u_host.desel;
        cmd(8'hAB, 8'h00);
        ask(SG);
        u_host.desel;
        cmd(8'h90, 8'h01);
        ask(DV);
        u_host.desel;
        chkBit(parallelMode, 1'b1);
        u_host.sel;
        send(8'h45);
        u_host.desel;
        chkBit(parallelMode, 1'b0);
        u_host.sel;
        send(8'h55);
        u_host.desel;
        @(posedge mclk) rst_n <= 1'b0;
        @(posedge mclk) rst_n <= 1'b1;
        @(posedge mclk);
        chkBit(parallelMode, 1'b0);
        // frozen clock enable: the opcode must not be taken
        @(posedge mclk) clkEn <= 1'b0;
        u_host.sel;
        send(8'h55);
        u_host.desel;
        chkBit(parallelMode, 1'b0);
        @(posedge mclk) clkEn <= 1'b1;
        $display("parallel mode done");
        wr(8'h20, 8'h00, 32'h1E);
        rd(8'hFF);
        wr(8'h02, 8'h3C, 32'h0A);
        rd(8'h3C);
        wr(8'hD8, 8'h00, 32'h28);
        rd(8'hFF);
        wr(8'h01, 8'hA8, 32'h14);
        chk8(statusReg, 8'hA8);
        $display("write timing done");
        end_sim;
    end
endmodule
